// file: ddrca_pkg.sv
// shared constants and types for the command/address decoder
// assumes all users reference items as ddrca_pkg::name
`default_nettype none

package ddrca_pkg;

  // bus widths
  localparam int BG_W = 2;
  localparam int BA_W = 2;
  localparam int ADDR_LO_W = 14;
  localparam int ROW_W = 18;
  localparam int COL_W = 10;
  localparam int OPCODE_W = 14;
  localparam int MR_COUNT = 8;
  localparam int MR_SEL_W = 3;
  localparam int PAR_VEC_W = 23;

  // address bit positions with a second meaning
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;

  // command codes on {ras_n, cas_n, we_n} with act_n high
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;

  // mode register holding the parity enable field
  localparam logic [MR_SEL_W-1:0] MR_PARITY_SEL = 3'h5;
  localparam int PAR_EN_LSB = 0;
  localparam int PAR_EN_W = 3;

  // values after reset
  localparam logic [OPCODE_W-1:0] MR_RESET = 14'h0000;
  localparam logic [ROW_W-1:0] ROW_RESET = 18'h00000;
  localparam logic [COL_W-1:0] COL_RESET = 10'h000;

  // cycle counts
  localparam int RESET_SYNC_STAGES = 3;
  localparam int RECOVER_CYCLES_DEFAULT = 64;

  // decoded command kinds
  typedef enum logic [2:0] {
    DDRCA_CMD_NONE,
    DDRCA_CMD_ACT,
    DDRCA_CMD_RD,
    DDRCA_CMD_WR,
    DDRCA_CMD_PRE,
    DDRCA_CMD_MRS,
    DDRCA_CMD_OTHER
  } ddrca_cmd_type;

  // parity error handling states
  typedef enum logic {
    DDRCA_ST_IDLE,
    DDRCA_ST_RECOVER
  } ddrca_state_type;

endpackage

`default_nettype wire

// file: ddrca_parity.sv
// even parity check over the command/address vector
// assumes the caller presents all covered bits in one vector
`timescale 1ns/1ps
`default_nettype none

module ddrca_parity #(
  parameter int VEC_W = ddrca_pkg::PAR_VEC_W
) (
  // covered bits and the parity pin
  input wire logic [VEC_W-1:0] cmd_bits,
  input wire logic parity_in,
  // checking switched on by the mode register
  input wire logic enable,
  // result
  output logic parity_bad
);

  // odd total count of ones is an error; disabled means no error at all
  assign parity_bad = enable & (^{parity_in, cmd_bits});

endmodule

`default_nettype wire

// file: ddrca_decode.sv
// command/address decoder as seen inside the memory device
// assumes clk is the rising true clock and the pins are synchronous to it
// Functional notes
// - bank group pins pick the bank group for act, read, write, precharge
// - mode register select comes from bg0 with the bank address pins
// - bank address pins pick the bank inside the chosen group
// - row taken on activate, column taken on read and write
// - address pins carry the op-code during mode register set
// - top address bit counts only in the 16 Gb x4 configuration
// - a10 high on read or write asks for auto precharge
// - a10 high on precharge closes all banks, low only the addressed one
// - a12 low on read or write chops the burst on the fly
// - even parity over parity, act, command, bank and address pins when enabled
// - active-low reset pin clears the device asynchronously
// - all command and address pins are sampled on the rising clock
// - commands are ignored while chip select is high
// - act low turns the three command pins into row bits 16 to 14
// - parity error pulls alert low until recovery has finished
`timescale 1ns/1ps
`default_nettype none

module ddrca_decode #(
  parameter bit USE_A17 = 1'b0,
  parameter int RECOVER_CYCLES = ddrca_pkg::RECOVER_CYCLES_DEFAULT
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  // command pins
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n_a16,
  input wire logic cas_n_a15,
  input wire logic we_n_a14,
  // bank, address and parity pins
  input wire logic [ddrca_pkg::BG_W-1:0] bg,
  input wire logic [ddrca_pkg::BA_W-1:0] ba,
  input wire logic addr_a17,
  input wire logic [ddrca_pkg::ADDR_LO_W-1:0] addr,
  input wire logic parity_in,
  // decoded access
  output logic cmd_valid,
  output ddrca_pkg::ddrca_cmd_type cmd_kind,
  output logic [ddrca_pkg::BG_W-1:0] bank_group,
  output logic [ddrca_pkg::BA_W-1:0] bank,
  output logic [ddrca_pkg::ROW_W-1:0] row,
  output logic [ddrca_pkg::COL_W-1:0] col,
  output logic auto_precharge,
  output logic precharge_all,
  output logic burst_chop,
  // mode register writes
  output logic mr_write,
  output logic [ddrca_pkg::MR_SEL_W-1:0] mr_select,
  output logic [ddrca_pkg::OPCODE_W-1:0] mr_opcode,
  // parity error reporting
  output logic parity_error,
  output logic alert_n
);

  localparam int CNT_W = (RECOVER_CYCLES > 2) ? $clog2(RECOVER_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RECOVER_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam int SYN = ddrca_pkg::RESET_SYNC_STAGES;

  logic [SYN-1:0] rst_pipe;
  logic [SYN-1:0] next_rst_pipe;
  logic run;
  ddrca_pkg::ddrca_state_type state;
  ddrca_pkg::ddrca_state_type next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [ddrca_pkg::OPCODE_W-1:0] mr [ddrca_pkg::MR_COUNT];
  logic par_en;
  logic par_bad;
  logic selected;
  logic accept;
  ddrca_pkg::ddrca_cmd_type kind;
  logic [ddrca_pkg::MR_SEL_W-1:0] sel;
  logic next_cmd_valid;
  ddrca_pkg::ddrca_cmd_type next_cmd_kind;
  logic [ddrca_pkg::BG_W-1:0] next_bank_group;
  logic [ddrca_pkg::BA_W-1:0] next_bank;
  logic [ddrca_pkg::ROW_W-1:0] next_row;
  logic [ddrca_pkg::COL_W-1:0] next_col;
  logic next_auto_precharge;
  logic next_precharge_all;
  logic next_burst_chop;
  logic next_mr_write;
  logic [ddrca_pkg::MR_SEL_W-1:0] next_mr_select;
  logic [ddrca_pkg::OPCODE_W-1:0] next_mr_opcode;
  logic next_parity_error;
  logic next_alert_n;

  // release of the reset pin is retimed; assertion is immediate via the async clear
  always_comb begin
    next_rst_pipe = {rst_pipe[SYN-2:0], 1'b1};
    if (rst) begin
      next_rst_pipe = '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= '0;
    end else begin
      rst_pipe <= next_rst_pipe;
    end
  end

  // first stage is read only by the second; later stages must agree
  assign run = rst_pipe[SYN-1] & rst_pipe[SYN-2];

  // parity enable lives in a field of the parity mode register
  assign par_en = |mr[ddrca_pkg::MR_PARITY_SEL][ddrca_pkg::PAR_EN_LSB +: ddrca_pkg::PAR_EN_W];

  ddrca_parity #(
    .VEC_W(ddrca_pkg::PAR_VEC_W)
  ) u_parity (
    .cmd_bits({act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr_a17, addr}),
    .parity_in(parity_in),
    .enable(par_en),
    .parity_bad(par_bad)
  );

  // a command is looked at only when selected and not recovering
  assign selected = !cs_n && run && (state == ddrca_pkg::DDRCA_ST_IDLE);
  assign accept = selected && !par_bad;
  assign sel = {bg[0], ba};

  // command kind; act low makes the command pins row address bits
  always_comb begin
    kind = ddrca_pkg::DDRCA_CMD_OTHER;
    if (!act_n) begin
      kind = ddrca_pkg::DDRCA_CMD_ACT;
    end else begin
      case ({ras_n_a16, cas_n_a15, we_n_a14})
        ddrca_pkg::CMD_MRS: kind = ddrca_pkg::DDRCA_CMD_MRS;
        ddrca_pkg::CMD_PRE: kind = ddrca_pkg::DDRCA_CMD_PRE;
        ddrca_pkg::CMD_RD: kind = ddrca_pkg::DDRCA_CMD_RD;
        ddrca_pkg::CMD_WR: kind = ddrca_pkg::DDRCA_CMD_WR;
        default: kind = ddrca_pkg::DDRCA_CMD_OTHER;
      endcase
    end
  end

  // mode register file, one entry per select code
  generate
    for (genvar i = 0; i < ddrca_pkg::MR_COUNT; i++) begin : g_mr
      logic [ddrca_pkg::OPCODE_W-1:0] next_mr;
      always_comb begin
        next_mr = mr[i];
        if (rst || !run) begin
          next_mr = ddrca_pkg::MR_RESET;
        end else if (accept && kind == ddrca_pkg::DDRCA_CMD_MRS &&
                     sel == ddrca_pkg::MR_SEL_W'(i)) begin
          next_mr = addr;
        end
      end
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mr[i] <= ddrca_pkg::MR_RESET;
        end else begin
          mr[i] <= next_mr;
        end
      end
    end
  endgenerate

  // decoded fields; they hold between commands, the strobes last one cycle
  always_comb begin
    next_cmd_valid = 1'b0;
    next_cmd_kind = cmd_kind;
    next_bank_group = bank_group;
    next_bank = bank;
    next_row = row;
    next_col = col;
    next_auto_precharge = auto_precharge;
    next_precharge_all = precharge_all;
    next_burst_chop = burst_chop;
    next_mr_write = 1'b0;
    next_mr_select = mr_select;
    next_mr_opcode = mr_opcode;
    if (rst || !run) begin
      next_cmd_kind = ddrca_pkg::DDRCA_CMD_NONE;
      next_bank_group = '0;
      next_bank = '0;
      next_row = ddrca_pkg::ROW_RESET;
      next_col = ddrca_pkg::COL_RESET;
      next_auto_precharge = 1'b0;
      next_precharge_all = 1'b0;
      next_burst_chop = 1'b0;
      next_mr_select = '0;
      next_mr_opcode = ddrca_pkg::MR_RESET;
    end else if (accept) begin
      next_cmd_valid = 1'b1;
      next_cmd_kind = kind;
      case (kind)
        ddrca_pkg::DDRCA_CMD_ACT: begin
          next_bank_group = bg;
          next_bank = ba;
          // top bit is not an address bit outside the x4 16 Gb part
          next_row = {addr_a17 & USE_A17, ras_n_a16, cas_n_a15, we_n_a14, addr};
        end
        ddrca_pkg::DDRCA_CMD_RD, ddrca_pkg::DDRCA_CMD_WR: begin
          next_bank_group = bg;
          next_bank = ba;
          next_col = addr[ddrca_pkg::COL_W-1:0];
          next_auto_precharge = addr[ddrca_pkg::AP_BIT];
          next_burst_chop = !addr[ddrca_pkg::BC_BIT];
        end
        ddrca_pkg::DDRCA_CMD_PRE: begin
          next_bank_group = bg;
          next_bank = ba;
          next_precharge_all = addr[ddrca_pkg::AP_BIT];
        end
        ddrca_pkg::DDRCA_CMD_MRS: begin
          next_mr_write = 1'b1;
          next_mr_select = sel;
          next_mr_opcode = addr;
        end
        default: begin
          next_cmd_kind = kind;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid <= 1'b0;
      cmd_kind <= ddrca_pkg::DDRCA_CMD_NONE;
      bank_group <= '0;
      bank <= '0;
      row <= ddrca_pkg::ROW_RESET;
      col <= ddrca_pkg::COL_RESET;
      auto_precharge <= 1'b0;
      precharge_all <= 1'b0;
      burst_chop <= 1'b0;
      mr_write <= 1'b0;
      mr_select <= '0;
      mr_opcode <= ddrca_pkg::MR_RESET;
    end else begin
      cmd_valid <= next_cmd_valid;
      cmd_kind <= next_cmd_kind;
      bank_group <= next_bank_group;
      bank <= next_bank;
      row <= next_row;
      col <= next_col;
      auto_precharge <= next_auto_precharge;
      precharge_all <= next_precharge_all;
      burst_chop <= next_burst_chop;
      mr_write <= next_mr_write;
      mr_select <= next_mr_select;
      mr_opcode <= next_mr_opcode;
    end
  end

  // parity error: alert low for a fixed recovery time, commands dropped meanwhile
  always_comb begin
    next_state = state;
    next_count = count;
    next_alert_n = alert_n;
    next_parity_error = 1'b0;
    if (rst || !run) begin
      next_state = ddrca_pkg::DDRCA_ST_IDLE;
      next_count = CNT_ZERO;
      next_alert_n = 1'b1;
    end else begin
      case (state)
        ddrca_pkg::DDRCA_ST_IDLE: begin
          if (selected && par_bad) begin
            next_state = ddrca_pkg::DDRCA_ST_RECOVER;
            next_count = CNT_LOAD;
            next_alert_n = 1'b0;
            next_parity_error = 1'b1;
          end
        end
        ddrca_pkg::DDRCA_ST_RECOVER: begin
          if (count == CNT_ZERO) begin
            next_state = ddrca_pkg::DDRCA_ST_IDLE;
            next_alert_n = 1'b1;
          end else begin
            next_count = count - 1'b1;
          end
        end
        default: begin
          next_state = ddrca_pkg::DDRCA_ST_IDLE;
          next_alert_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ddrca_pkg::DDRCA_ST_IDLE;
      count <= CNT_ZERO;
      alert_n <= 1'b1;
      parity_error <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      alert_n <= next_alert_n;
      parity_error <= next_parity_error;
    end
  end

  // helper: length of the current alert low phase
  logic [CNT_W:0] low_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= alert_n ? '0 : low_cnt + 1'b1;
    end
  end

  a_cs_masked: assert property (@(posedge clk) disable iff (rst || !reset_n)
    cs_n |=> !cmd_valid && !parity_error)
    else $error("command taken with chip select high");

  a_bg_bank: assert property (@(posedge clk) disable iff (rst || !reset_n)
    accept && (kind == ddrca_pkg::DDRCA_CMD_ACT || kind == ddrca_pkg::DDRCA_CMD_RD)
    |=> cmd_valid && bank_group == $past(bg) && bank == $past(ba))
    else $error("bank group or bank not captured");

  a_row_pins: assert property (@(posedge clk) disable iff (rst || !reset_n)
    accept && !act_n |=> cmd_kind == ddrca_pkg::DDRCA_CMD_ACT &&
    row[16:14] == $past({ras_n_a16, cas_n_a15, we_n_a14}) &&
    row[13:0] == $past(addr))
    else $error("row address wrong on activate");

  a_a17_unused: assert property (@(posedge clk) disable iff (rst || !reset_n)
    !USE_A17 |-> row[17] == 1'b0)
    else $error("top row bit set in a configuration without it");

  a_col_flags: assert property (@(posedge clk) disable iff (rst || !reset_n)
    accept && (kind == ddrca_pkg::DDRCA_CMD_RD || kind == ddrca_pkg::DDRCA_CMD_WR)
    |=> col == $past(addr[9:0]) && auto_precharge == $past(addr[10]) &&
    burst_chop == !$past(addr[12]))
    else $error("column, auto precharge or burst chop wrong");

  a_pre_all: assert property (@(posedge clk) disable iff (rst || !reset_n)
    accept && kind == ddrca_pkg::DDRCA_CMD_PRE
    |=> cmd_kind == ddrca_pkg::DDRCA_CMD_PRE && precharge_all == $past(addr[10]))
    else $error("precharge scope wrong");

  a_mr_write: assert property (@(posedge clk) disable iff (rst || !reset_n)
    accept && kind == ddrca_pkg::DDRCA_CMD_MRS
    |=> mr_write && mr_select == $past({bg[0], ba}) && mr_opcode == $past(addr))
    else $error("mode register write wrong");

  a_par_flag: assert property (@(posedge clk) disable iff (rst || !reset_n)
    selected && par_en && (^{parity_in, act_n, ras_n_a16, cas_n_a15, we_n_a14,
    bg, ba, addr_a17, addr}) |=> parity_error && !alert_n && !cmd_valid)
    else $error("parity error not flagged");

  a_par_off: assert property (@(posedge clk) disable iff (rst || !reset_n)
    !par_en |=> !parity_error)
    else $error("parity error while checking is off");

  a_alert_len: assert property (@(posedge clk) disable iff (rst || !reset_n)
    $rose(alert_n) |-> low_cnt == (CNT_W + 1)'(RECOVER_CYCLES))
    else $error("alert low for the wrong time");

  a_alert_bound: assert property (@(posedge clk) disable iff (rst || !reset_n)
    low_cnt <= (CNT_W + 1)'(RECOVER_CYCLES))
    else $error("alert held low too long");

  a_reset_pin: assert property (@(posedge clk) disable iff (rst)
    !reset_n |-> alert_n && !cmd_valid && !mr_write && !parity_error)
    else $error("outputs not cleared under the reset pin");

endmodule

`default_nettype wire

// file: ddrca_host_model.sv
// host controller model driving the device command/address and reset pins
// assumes clk is the device clock; the bench calls issue, idle and set_reset
`timescale 1ns/1ps
`default_nettype none

module ddrca_host_model (
  // clock from the bench
  input wire logic clk,
  // reset pin
  output logic reset_n,
  // command pins
  output logic cs_n,
  output logic act_n,
  output logic ras_n_a16,
  output logic cas_n_a15,
  output logic we_n_a14,
  // bank, address and parity pins
  output logic [ddrca_pkg::BG_W-1:0] bg,
  output logic [ddrca_pkg::BA_W-1:0] ba,
  output logic addr_a17,
  output logic [ddrca_pkg::ADDR_LO_W-1:0] addr,
  output logic parity_in
);
  // start deselected with the device held in reset
  initial begin
    reset_n = 1'b0;
    cs_n = 1'b1;
    {act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr_a17, addr, parity_in} = '0;
  end

  // one command per edge; bad flips the parity pin on purpose
  task automatic issue(input logic cs, input logic act, input logic [2:0] code,
      input logic [1:0] g, input logic [1:0] b, input logic a17, input logic [13:0] a,
      input logic bad);
    @(posedge clk);
    cs_n <= cs;
    {act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr_a17, addr} <= {act, code, g, b, a17, a};
    parity_in <= ^{act, code, g, b, a17, a} ^ bad; // even count with parity
  endtask

  // deselect; released lines flip so a stale value never looks valid
  task automatic idle();
    @(posedge clk);
    cs_n <= 1'b1;
    {act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr_a17, addr, parity_in} <=
      ~{act_n, ras_n_a16, cas_n_a15, we_n_a14, bg, ba, addr_a17, addr, parity_in};
  endtask

  // reset pin changes at an edge; it stays high in normal operation
  task automatic set_reset(input logic v);
    @(posedge clk);
    reset_n <= v;
  endtask
endmodule

`default_nettype wire

// file: ddrca_decode_tb_top.sv
// self-checking bench for the command/address decoder
// assumes ddrca_pkg, ddrca_decode and ddrca_host_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module ddrca_decode_tb_top;
  localparam int RC = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic reset_n, cs_n, act_n, ras_n_a16, cas_n_a15, we_n_a14, addr_a17, parity_in;
  wire logic [1:0] bg, ba;
  wire logic [13:0] addr;
  logic cmd_valid, auto_precharge, precharge_all, burst_chop, mr_write, parity_error, alert_n;
  ddrca_pkg::ddrca_cmd_type cmd_kind;
  logic [1:0] bank_group, bank;
  logic [17:0] row;
  logic [9:0] col;
  logic [2:0] mr_select;
  logic [13:0] mr_opcode;
  int err_total = 0;
  int tests_run = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  ddrca_host_model host_u (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .act_n(act_n),
    .ras_n_a16(ras_n_a16), .cas_n_a15(cas_n_a15), .we_n_a14(we_n_a14), .bg(bg), .ba(ba),
    .addr_a17(addr_a17), .addr(addr), .parity_in(parity_in));

  // short recovery keeps the alert scenario brief
  ddrca_decode #(.USE_A17(1'b0), .RECOVER_CYCLES(RC)) dut_u (.clk(clk), .rst(rst),
    .reset_n(reset_n), .cs_n(cs_n), .act_n(act_n), .ras_n_a16(ras_n_a16),
    .cas_n_a15(cas_n_a15), .we_n_a14(we_n_a14), .bg(bg), .ba(ba), .addr_a17(addr_a17),
    .addr(addr), .parity_in(parity_in), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .bank_group(bank_group), .bank(bank), .row(row), .col(col),
    .auto_precharge(auto_precharge), .precharge_all(precharge_all), .burst_chop(burst_chop),
    .mr_write(mr_write), .mr_select(mr_select), .mr_opcode(mr_opcode),
    .parity_error(parity_error), .alert_n(alert_n));

  task automatic print_verdict();
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one selected command, then look just after the edge that takes it
  task automatic send(input logic act, input logic [2:0] code, input logic [1:0] g,
      input logic [1:0] b, input logic [13:0] a, input logic bad);
    host_u.issue(1'b0, act, code, g, b, 1'b1, a, bad);
    host_u.idle();
    #1;
  endtask

  task automatic t_activate();
    send(1'b0, 3'h5, 2'h2, 2'h1, 14'h2ABC, 1'b0);
    chk("act_valid", 1, cmd_valid);
    chk("act_kind", ddrca_pkg::DDRCA_CMD_ACT, cmd_kind);
    chk("act_bg", 2'h2, bank_group);
    chk("act_ba", 2'h1, bank);
    chk("act_row", {1'b0, 3'h5, 14'h2ABC}, row);
    @(posedge clk);
    #1;
    chk("act_pulse", 0, cmd_valid);
    // deselected activate must leave the row alone
    host_u.issue(1'b1, 1'b0, 3'h2, 2'h1, 2'h2, 1'b0, 14'h1111, 1'b0);
    host_u.idle();
    #1;
    chk("desel_valid", 0, cmd_valid);
    chk("desel_row", {1'b0, 3'h5, 14'h2ABC}, row);
  endtask

  // read and write back to back
  task automatic t_read_write();
    host_u.issue(1'b0, 1'b1, 3'h5, 2'h1, 2'h3, 1'b0, 14'h07A5, 1'b0);
    host_u.issue(1'b0, 1'b1, 3'h4, 2'h3, 2'h0, 1'b0, 14'h1155, 1'b0);
    #1;
    chk("rd_valid", 1, cmd_valid);
    chk("rd_kind", ddrca_pkg::DDRCA_CMD_RD, cmd_kind);
    chk("rd_col", 10'h3A5, col);
    chk("rd_bg_ba", 4'h7, {bank_group, bank});
    chk("rd_ap", 1, auto_precharge);
    chk("rd_bc", 1, burst_chop);
    host_u.idle();
    #1;
    chk("wr_valid", 1, cmd_valid);
    chk("wr_kind", ddrca_pkg::DDRCA_CMD_WR, cmd_kind);
    chk("wr_col", 10'h155, col);
    chk("wr_ap", 0, auto_precharge);
    chk("wr_bc", 0, burst_chop);
  endtask

  task automatic t_precharge();
    for (int i = 0; i < 2; i++) begin
      send(1'b1, 3'h2, 2'(i + 1), 2'(i + 2), {3'h0, 1'(i), 10'h000}, 1'b0);
      chk("pre_kind", ddrca_pkg::DDRCA_CMD_PRE, cmd_kind);
      chk("pre_all", i, precharge_all);
      chk("pre_bank", {2'(i + 1), 2'(i + 2)}, {bank_group, bank});
    end
    send(1'b1, 3'h1, 2'h0, 2'h0, 14'h0000, 1'b0);
    chk("ref_kind", ddrca_pkg::DDRCA_CMD_OTHER, cmd_kind);
  endtask

  // bg1 set high must not reach the register select
  task automatic t_mode_set();
    send(1'b1, 3'h0, 2'h3, 2'h2, 14'h3C5A, 1'b0);
    chk("mrs_write", 1, mr_write);
    chk("mrs_kind", ddrca_pkg::DDRCA_CMD_MRS, cmd_kind);
    chk("mrs_sel", 3'h6, mr_select);
    chk("mrs_op", 14'h3C5A, mr_opcode);
  endtask

  task automatic t_parity();
    send(1'b1, 3'h5, 2'h0, 2'h0, 14'h0001, 1'b1);
    chk("off_valid", 1, cmd_valid);
    chk("off_perr", 0, parity_error);
    send(1'b1, 3'h0, 2'h1, 2'h1, 14'h0001, 1'b0);
    send(1'b1, 3'h5, 2'h2, 2'h1, 14'h0123, 1'b1);
    chk("bad_valid", 0, cmd_valid);
    chk("bad_perr", 1, parity_error);
    chk("bad_alert", 0, alert_n);
    send(1'b1, 3'h4, 2'h0, 2'h0, 14'h0002, 1'b0);
    chk("rec_drop", 0, cmd_valid);
    @(posedge clk);
    #1;
    chk("rec_alert", 0, alert_n);
    @(posedge clk);
    #1;
    chk("rec_end", 1, alert_n);
    send(1'b1, 3'h4, 2'h0, 2'h0, 14'h0002, 1'b0);
    chk("post_valid", 1, cmd_valid);
  endtask

  // reset pin clears without waiting for an edge and drops parity checking
  task automatic t_async_reset();
    host_u.set_reset(1'b0);
    #1;
    chk("ar_row", 0, row);
    chk("ar_kind", ddrca_pkg::DDRCA_CMD_NONE, cmd_kind);
    host_u.set_reset(1'b1);
    repeat (3) @(posedge clk);
    send(1'b1, 3'h5, 2'h0, 2'h0, 14'h0004, 1'b1);
    chk("ar_valid", 1, cmd_valid);
    chk("ar_perr", 0, parity_error);
  endtask

  // watchdog of 1000 cycles, well above the 55 or so cycles the tests need
  initial begin
    #(1000 * 100);
    err_total++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    host_u.set_reset(1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk("rst_alert", 1, alert_n);
    chk("rst_valid", 0, cmd_valid);
    t_activate();
    t_read_write();
    t_precharge();
    t_mode_set();
    t_parity();
    t_async_reset();
    print_verdict();
  end
endmodule

`default_nettype wire
